// file: rtl/swcw_config_regs.sv
`timescale 1ns/1ps

//------------------------------------------------------------
// Overview of operation
// - stop-mode watchdog deactivation needs both pair bits set.
// - second deactivation bit clears on stop to normal transition.
// - watchdog type bit selects time-out (0) or window (1).
// - bus-wake start bit lets a stop-mode bus wake start the watchdog.
// - period code 000..111 maps to 10 ms up to 10000 ms.
// - reserved bits always read zero.
// - mode codes off, wake capable, receive only, normal; top bit selective wake.
// - hardware never changes the selective-wake bit.
// - sleep entry without system error turns normal into wake capable.
// - receive only becomes wake capable on sleep, stays on stop.
// - wake capable or off stays unchanged on sleep or stop entry.
// - fail-safe entry rewrites transceiver mode to 0000 0x01.
// - development mode resets transceiver mode to normal without selective wake.
// - internal wake bit 6 enables cyclic timer wake.
// - global interrupt bit chooses wake-only or all status interrupt sources.
// - voltage sense select suppresses wake events from the wake input.
// - external wake bit 0 enables the high-voltage wake input.
// - watchdog setup sits at address 0000011, reset value 0001 0100.
//------------------------------------------------------------

module swcw_config_regs (
    // clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // register port from the serial frame decoder
    input wire logic i_reg_wr,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // chip state and events, same clock
    input wire swcw_pkg::swcw_mode_t i_sbc_mode,
    input wire logic i_soft_reset,
    input wire logic i_fail_safe_entry,
    input wire logic i_system_error_flag,
    input wire logic i_bus_wake_in_stop,
    input wire logic i_timer_wake,
    input wire logic i_status_event,
    // pins from outside the clock domain
    input wire logic i_dev_mode_pin,
    input wire logic i_hv_wake_input,
    // watchdog configuration outputs
    output logic o_wdog_type_window,
    output logic [13:0] o_wdog_period_ms,
    output logic o_wdog_stop_off,
    output logic o_wdog_start_long_window,
    output logic o_wdog_cfg_parity_err,
    // transceiver and wake outputs
    output logic [2:0] o_can_mode,
    output logic o_cyclic_timer_wake_enable,
    output logic o_voltage_sense_select,
    output logic o_wake_event,
    output logic o_interrupt_out_n
);

    import swcw_pkg::*;

    //------------------------------------------------------------
    // functions
    //------------------------------------------------------------

    // period code to milliseconds
    function automatic logic [13:0] period_ms(input logic [2:0] code);
        case (code)
            3'h0: return SWCW_WD_MS_0;
            3'h1: return SWCW_WD_MS_1;
            3'h2: return SWCW_WD_MS_2;
            3'h3: return SWCW_WD_MS_3;
            3'h4: return SWCW_WD_MS_4;
            3'h5: return SWCW_WD_MS_5;
            3'h6: return SWCW_WD_MS_6;
            default: return SWCW_WD_MS_7;
        endcase
    endfunction : period_ms

    // masked write, reserved positions forced to zero
    function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
        return data & mask;
    endfunction : masked

    // sleep-entry mapping of the low two transceiver mode bits
    // stop entry has no branch, so the mode is kept
    function automatic logic [1:0] sleep_map(input logic [1:0] cur, input logic system_error_flag);
        case (cur)
            SWCW_XCVR_NORMAL: return system_error_flag ? cur : SWCW_XCVR_WAKE_CAP;
            SWCW_XCVR_RX_ONLY: return SWCW_XCVR_WAKE_CAP;
            default: return cur;
        endcase
    endfunction : sleep_map

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------

    logic [1:0] pins_sync;
    logic dev_mode_s;
    logic hv_wake_s;

    swcw_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_async({i_dev_mode_pin, i_hv_wake_input}),
        .o_sync(pins_sync)
    );

    assign dev_mode_s = pins_sync[1];
    assign hv_wake_s = pins_sync[0];

    //------------------------------------------------------------
    // decode and chip mode transitions
    //------------------------------------------------------------

    logic wr_wdog;
    logic wr_xcvr;
    logic wr_iwake;
    logic wr_ewake;
    swcw_mode_t mode_prev_q;
    logic enter_sleep;
    logic stop_to_normal;
    logic [1:0] strap_cnt_q;
    logic strap_load;

    // register strobes
    assign wr_wdog = i_reg_wr && (i_reg_addr == SWCW_ADDR_WDOG_SETUP);
    assign wr_xcvr = i_reg_wr && (i_reg_addr == SWCW_ADDR_XCVR_MODE);
    assign wr_iwake = i_reg_wr && (i_reg_addr == SWCW_ADDR_INT_WAKE);
    assign wr_ewake = i_reg_wr && (i_reg_addr == SWCW_ADDR_EXT_WAKE);

    // previous chip mode for edge detection
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_prev_q <= SWCW_MODE_NORMAL;
        end else if (i_clk_en) begin
            mode_prev_q <= i_sbc_mode;
        end
    end

    assign enter_sleep = (i_sbc_mode == SWCW_MODE_SLEEP) && (mode_prev_q != SWCW_MODE_SLEEP);
    assign stop_to_normal = (i_sbc_mode == SWCW_MODE_NORMAL) && (mode_prev_q == SWCW_MODE_STOP);

    // strap trusted only once the synchroniser has filled
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            strap_cnt_q <= 2'h0;
        end else if (i_clk_en && strap_cnt_q != SWCW_STRAP_SETTLE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
        end
    end

    // one-cycle strobe while the count is one below the settle count
    assign strap_load = (strap_cnt_q == SWCW_STRAP_SETTLE - 2'h1);

    //------------------------------------------------------------
    // watchdog setup register
    //------------------------------------------------------------

    logic [7:0] wdog_q;

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wdog_q <= SWCW_RST_WDOG_SETUP;
        end else if (i_clk_en) begin
            if (i_soft_reset) begin
                wdog_q <= SWCW_RST_WDOG_SETUP;
            end else if (wr_wdog) begin
                wdog_q <= masked(i_reg_wdata, SWCW_MASK_WDOG_SETUP);
            end
        end
    end

    //------------------------------------------------------------
    // transceiver mode register
    //------------------------------------------------------------

    logic swk_q;
    logic [1:0] xcvr_lo_q;
    logic [1:0] xcvr_lo_d;

    // selective-wake bit follows software only
    // hardware never touches
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            swk_q <= SWCW_RST_XCVR_MODE[SWCW_XCVR_SWK_BIT];
        end else if (i_clk_en) begin
            if (i_soft_reset) begin
                swk_q <= SWCW_RST_XCVR_MODE[SWCW_XCVR_SWK_BIT];
            end else if (wr_xcvr) begin
                swk_q <= i_reg_wdata[SWCW_XCVR_SWK_BIT];
            end
        end
    end

    // low bits: hardware events outrank a write in the same cycle
    always_comb begin
        xcvr_lo_d = xcvr_lo_q;
        if (wr_xcvr) begin
            xcvr_lo_d = i_reg_wdata[1:0];
        end
        if (i_fail_safe_entry) begin
            xcvr_lo_d = SWCW_XCVR_WAKE_CAP;
        end else if (enter_sleep) begin
            xcvr_lo_d = sleep_map(xcvr_lo_q, i_system_error_flag);
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            xcvr_lo_q <= SWCW_RST_XCVR_MODE[1:0];
        end else if (i_clk_en) begin
            if (i_soft_reset || strap_load) begin
                xcvr_lo_q <= dev_mode_s ? SWCW_DEV_XCVR_MODE[1:0] : SWCW_RST_XCVR_MODE[1:0];
            end else begin
                xcvr_lo_q <= xcvr_lo_d;
            end
        end
    end

    //------------------------------------------------------------
    // internal and external wake registers
    //------------------------------------------------------------

    logic [7:0] iwake_q;
    logic [7:0] ewake_q;

    // internal wake: timer enable and second stop-deactivation bit
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            iwake_q <= SWCW_RST_INT_WAKE;
        end else if (i_clk_en) begin
            if (i_soft_reset) begin
                iwake_q <= SWCW_RST_INT_WAKE;
            end else begin
                if (wr_iwake) begin
                    iwake_q <= masked(i_reg_wdata, SWCW_MASK_INT_WAKE);
                end
                if (stop_to_normal) begin
                    iwake_q[SWCW_IW_STOP_OFF_HI_BIT] <= 1'b0;
                end
            end
        end
    end

    // external wake: global interrupt, voltage sense, wake enable
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ewake_q <= SWCW_RST_EXT_WAKE;
        end else if (i_clk_en) begin
            if (i_soft_reset) begin
                ewake_q <= SWCW_RST_EXT_WAKE;
            end else if (wr_ewake) begin
                ewake_q <= masked(i_reg_wdata, SWCW_MASK_EXT_WAKE);
            end
        end
    end

    //------------------------------------------------------------
    // read path
    //------------------------------------------------------------

    logic [7:0] rdata_d;

    always_comb begin
        case (i_reg_addr)
            SWCW_ADDR_WDOG_SETUP: rdata_d = wdog_q & SWCW_MASK_WDOG_SETUP;
            SWCW_ADDR_XCVR_MODE: rdata_d = {5'h00, swk_q, xcvr_lo_q};
            SWCW_ADDR_INT_WAKE: rdata_d = iwake_q & SWCW_MASK_INT_WAKE;
            SWCW_ADDR_EXT_WAKE: rdata_d = ewake_q & SWCW_MASK_EXT_WAKE;
            default: rdata_d = 8'h00;
        endcase
    end

    // read data one cycle after the address
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 8'h00;
        end else if (i_clk_en) begin
            o_reg_rdata <= rdata_d;
        end
    end

    //------------------------------------------------------------
    // watchdog configuration outputs
    //------------------------------------------------------------

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wdog_type_window <= SWCW_RST_WDOG_SETUP[SWCW_WD_TYPE_BIT];
            o_wdog_period_ms <= period_ms(SWCW_RST_WDOG_SETUP[SWCW_WD_PERIOD_MSB:0]);
            o_wdog_stop_off <= 1'b0;
            o_wdog_cfg_parity_err <= 1'b0;
            o_wdog_start_long_window <= 1'b0;
        end else if (i_clk_en) begin
            o_wdog_type_window <= wdog_q[SWCW_WD_TYPE_BIT];
            o_wdog_period_ms <= period_ms(wdog_q[SWCW_WD_PERIOD_MSB:0]);
            o_wdog_stop_off <= wdog_q[SWCW_WD_STOP_OFF_LO_BIT] & iwake_q[SWCW_IW_STOP_OFF_HI_BIT];
            // odd parity flagged, software keeps it even
            o_wdog_cfg_parity_err <= ^wdog_q;
            o_wdog_start_long_window <= i_bus_wake_in_stop & wdog_q[SWCW_WD_BUS_WAKE_BIT];
        end
    end

    //------------------------------------------------------------
    // transceiver and wake outputs
    //------------------------------------------------------------

    logic hv_prev_q;
    logic wake_now;

    // edge on the synchronised wake input
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            hv_prev_q <= 1'b0;
        end else if (i_clk_en) begin
            hv_prev_q <= hv_wake_s;
        end
    end

    assign wake_now = ((hv_wake_s ^ hv_prev_q) && ewake_q[SWCW_EW_HV_WAKE_BIT]
                       && !ewake_q[SWCW_EW_VSENSE_BIT])
                   || (i_timer_wake && iwake_q[SWCW_IW_TIMER_BIT]);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_can_mode <= SWCW_RST_XCVR_MODE[2:0];
            o_cyclic_timer_wake_enable <= 1'b0;
            o_voltage_sense_select <= 1'b0;
            o_wake_event <= 1'b0;
            o_interrupt_out_n <= 1'b1;
        end else if (i_clk_en) begin
            o_can_mode <= {swk_q, xcvr_lo_q};
            o_cyclic_timer_wake_enable <= iwake_q[SWCW_IW_TIMER_BIT];
            o_voltage_sense_select <= ewake_q[SWCW_EW_VSENSE_BIT];
            o_wake_event <= wake_now;
            // interrupt low one cycle per qualifying event
            o_interrupt_out_n <= !(wake_now || (i_status_event && ewake_q[SWCW_EW_INT_GLOBAL_BIT]));
        end
    end

endmodule : swcw_config_regs

// file: rtl/swcw_pkg.sv
package swcw_pkg;

    // ------------------------------------------------------------
    // register map (seven-bit addresses)
    // ------------------------------------------------------------
    localparam logic [6:0] SWCW_ADDR_WDOG_SETUP = 7'h03;
    localparam logic [6:0] SWCW_ADDR_XCVR_MODE = 7'h04;
    localparam logic [6:0] SWCW_ADDR_INT_WAKE = 7'h06;
    localparam logic [6:0] SWCW_ADDR_EXT_WAKE = 7'h07;

    // ------------------------------------------------------------
    // values after power-on or soft reset
    // ------------------------------------------------------------
    localparam logic [7:0] SWCW_RST_WDOG_SETUP = 8'h14;
    localparam logic [7:0] SWCW_RST_XCVR_MODE = 8'h00;
    localparam logic [7:0] SWCW_RST_INT_WAKE = 8'h00;
    localparam logic [7:0] SWCW_RST_EXT_WAKE = 8'h01;
    // transceiver mode loaded instead of off in development mode
    localparam logic [2:0] SWCW_DEV_XCVR_MODE = 3'h3;

    // ------------------------------------------------------------
    // writable bit masks, reserved bits stay zero
    // ------------------------------------------------------------
    localparam logic [7:0] SWCW_MASK_WDOG_SETUP = 8'hf7;
    localparam logic [7:0] SWCW_MASK_XCVR_MODE = 8'h07;
    localparam logic [7:0] SWCW_MASK_INT_WAKE = 8'h44;
    localparam logic [7:0] SWCW_MASK_EXT_WAKE = 8'ha1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SWCW_WD_CHECKSUM_BIT = 7;
    localparam int SWCW_WD_STOP_OFF_LO_BIT = 6;
    localparam int SWCW_WD_TYPE_BIT = 5;
    localparam int SWCW_WD_BUS_WAKE_BIT = 4;
    localparam int SWCW_WD_PERIOD_MSB = 2;
    localparam int SWCW_XCVR_SWK_BIT = 2;
    localparam int SWCW_IW_TIMER_BIT = 6;
    localparam int SWCW_IW_STOP_OFF_HI_BIT = 2;
    localparam int SWCW_EW_INT_GLOBAL_BIT = 7;
    localparam int SWCW_EW_VSENSE_BIT = 5;
    localparam int SWCW_EW_HV_WAKE_BIT = 0;

    // ------------------------------------------------------------
    // transceiver mode codes (low two bits)
    // ------------------------------------------------------------
    localparam logic [1:0] SWCW_XCVR_OFF = 2'h0;
    localparam logic [1:0] SWCW_XCVR_WAKE_CAP = 2'h1;
    localparam logic [1:0] SWCW_XCVR_RX_ONLY = 2'h2;
    localparam logic [1:0] SWCW_XCVR_NORMAL = 2'h3;

    // ------------------------------------------------------------
    // chip operating modes as reported by the mode controller
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SWCW_MODE_NORMAL = 2'h0,
        SWCW_MODE_SLEEP = 2'h1,
        SWCW_MODE_STOP = 2'h2,
        SWCW_MODE_RESET = 2'h3
    } swcw_mode_t;

    // ------------------------------------------------------------
    // watchdog periods in milliseconds, code 000 to 111
    // ------------------------------------------------------------
    localparam logic [13:0] SWCW_WD_MS_0 = 14'd10;
    localparam logic [13:0] SWCW_WD_MS_1 = 14'd20;
    localparam logic [13:0] SWCW_WD_MS_2 = 14'd50;
    localparam logic [13:0] SWCW_WD_MS_3 = 14'd100;
    localparam logic [13:0] SWCW_WD_MS_4 = 14'd200;
    localparam logic [13:0] SWCW_WD_MS_5 = 14'd500;
    localparam logic [13:0] SWCW_WD_MS_6 = 14'd1000;
    localparam logic [13:0] SWCW_WD_MS_7 = 14'd10000;

    // cycles the strap synchroniser needs before the strap is trusted
    localparam logic [1:0] SWCW_STRAP_SETTLE = 2'h3;

endpackage : swcw_pkg

// file: rtl/swcw_sync.sv
`timescale 1ns/1ps

module swcw_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // two stages, the first is read only by the second
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (i_clk_en) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : swcw_sync

// file: verification/swcw_checker.sv
`timescale 1ns/1ps

// ----------------------------------------
// port checker for the configuration slice
// ----------------------------------------
module swcw_checker (
    // watched ports
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_reg_wr,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire swcw_pkg::swcw_mode_t i_sbc_mode,
    input wire logic i_soft_reset,
    input wire logic i_fail_safe_entry,
    input wire logic i_system_error_flag,
    input wire logic i_bus_wake_in_stop,
    input wire logic i_status_event,
    input wire logic o_wdog_type_window,
    input wire logic [13:0] o_wdog_period_ms,
    input wire logic o_wdog_stop_off,
    input wire logic o_wdog_start_long_window,
    input wire logic o_wdog_cfg_parity_err,
    input wire logic [2:0] o_can_mode,
    input wire logic o_wake_event,
    input wire logic o_interrupt_out_n
);
    import swcw_pkg::*;
    localparam logic [13:0] WD_MS [8] = '{14'h00a, 14'h014, 14'h032, 14'h064,
        14'h0c8, 14'h1f4, 14'h3e8, 14'h2710};
    // one clock domain, one reset
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    // reserved bits of the mode register
    property p_rsvd;
        $past(i_reg_addr) == 7'h04 |-> o_reg_rdata[7:3] == 5'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_wd_write;
        i_reg_wr && i_reg_addr == 7'h03 && !i_soft_reset |-> ##2
            o_wdog_period_ms == WD_MS[$past(i_reg_wdata[2:0], 2)] &&
            o_wdog_type_window == $past(i_reg_wdata[5], 2) &&
            o_wdog_cfg_parity_err == ^($past(i_reg_wdata, 2) & 8'hf7);
    endproperty
    a_wd_write: assert property (p_wd_write) else $error("setup outputs wrong");
    property p_stop_clr;
        i_sbc_mode == SWCW_MODE_NORMAL && $past(i_sbc_mode) == SWCW_MODE_STOP
            |-> ##2 !o_wdog_stop_off;
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop off kept");
    // long window only from a bus wake
    property p_bus;
        o_wdog_start_long_window |-> $past(i_bus_wake_in_stop);
    endproperty
    a_bus: assert property (p_bus) else $error("long window without wake");
    property p_sleep;
        i_sbc_mode == SWCW_MODE_SLEEP && $past(i_sbc_mode) != SWCW_MODE_SLEEP &&
            !i_system_error_flag |-> ##3 !o_can_mode[1];
    endproperty
    a_sleep: assert property (p_sleep) else $error("transceiver active in sleep");
    // selective wake bit moves only by software
    property p_sw_keep;
        $changed(o_can_mode[2]) |-> ($past(i_reg_wr, 2) && $past(i_reg_addr, 2) == 7'h04)
            || $past(i_soft_reset, 2);
    endproperty
    a_sw_keep: assert property (p_sw_keep) else $error("selective wake moved");
    property p_failsafe;
        i_fail_safe_entry |-> ##2 o_can_mode[1:0] == 2'h1;
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("fail-safe mode wrong");
    // interrupt has a wake or status cause
    property p_int;
        !o_interrupt_out_n |-> o_wake_event || $past(i_status_event) || $past(i_status_event, 2);
    endproperty
    a_int: assert property (p_int) else $error("interrupt without cause");

    // main scenarios reached
    c_fail: cover property (i_fail_safe_entry);
    c_sleep: cover property (i_sbc_mode == SWCW_MODE_SLEEP && $past(i_sbc_mode) != SWCW_MODE_SLEEP);
    c_wake: cover property (o_wake_event);
endmodule : swcw_checker

bind swcw_config_regs swcw_checker swcw_checker_i (.i_mclk, .i_resetn, .i_reg_wr, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .i_sbc_mode, .i_soft_reset, .i_fail_safe_entry,
    .i_system_error_flag, .i_bus_wake_in_stop, .i_status_event, .o_wdog_type_window,
    .o_wdog_period_ms, .o_wdog_stop_off, .o_wdog_start_long_window, .o_wdog_cfg_parity_err,
    .o_can_mode, .o_wake_event, .o_interrupt_out_n);

// file: verification/swcw_mcu_model.sv
`timescale 1ns/1ps

// register port master, drives on falling edges
module swcw_mcu_model (
    // register port
    input wire logic i_mclk,
    input wire logic [7:0] i_rdata,
    output logic o_wr,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata
);
    int slow = 0; // idle cycles before each access, models a busy core
    initial begin
        o_wr = 1'b0;
        o_addr = 7'h00;
        o_wdata = 8'h00;
    end
    function automatic logic [7:0] wd_byte(input logic [6:0] v);
        return {^v, v};
    endfunction : wd_byte
    // one strobe cycle per write
    task automatic write(input logic [6:0] a, input logic [7:0] d);
        repeat (slow) @(negedge i_mclk);
        @(negedge i_mclk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask : write
    // data answers one edge after the address
    task automatic read(input logic [6:0] a, output logic [7:0] q);
        repeat (slow) @(negedge i_mclk);
        o_addr = a;
        @(negedge i_mclk);
        q = i_rdata;
    endtask : read
endmodule : swcw_mcu_model

// file: verification/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module testbench;
    import swcw_pkg::*;
    localparam logic [13:0] MS [8] = '{14'h00a, 14'h014, 14'h032, 14'h064,
        14'h0c8, 14'h1f4, 14'h3e8, 14'h2710};
    logic i_mclk, i_resetn = 0, i_soft_reset = 0, i_fail_safe_entry = 0;
    logic i_system_error_flag = 0, i_bus_wake_in_stop = 0, i_timer_wake = 0;
    logic i_status_event = 0, i_dev_mode_pin = 0, i_hv_wake_input = 0, i_reg_wr;
    logic [6:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata;
    swcw_mode_t i_sbc_mode = SWCW_MODE_NORMAL;
    logic [13:0] o_wdog_period_ms;
    logic [2:0] o_can_mode;
    logic o_wdog_type_window, o_wdog_stop_off, o_wdog_start_long_window, o_wdog_cfg_parity_err;
    logic o_cyclic_timer_wake_enable, o_voltage_sense_select, o_wake_event, o_interrupt_out_n;
    logic [7:0] m [128] = '{3: 8'h14, 7: 8'h01, default: 8'h00}; // register model
    logic [31:0] r;
    int mismatches = 0, total_checks = 0, cyc = 0, wakes = 0, ints = 0, ew;

    swcw_config_regs swcw_config_regs_i (.i_mclk, .i_resetn, .i_clk_en(1'b1), .i_reg_wr,
        .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_sbc_mode, .i_soft_reset, .i_fail_safe_entry,
        .i_system_error_flag, .i_bus_wake_in_stop, .i_timer_wake, .i_status_event,
        .i_dev_mode_pin, .i_hv_wake_input, .o_wdog_type_window, .o_wdog_period_ms,
        .o_wdog_stop_off, .o_wdog_start_long_window, .o_wdog_cfg_parity_err, .o_can_mode,
        .o_cyclic_timer_wake_enable, .o_voltage_sense_select, .o_wake_event, .o_interrupt_out_n);
    swcw_mcu_model mcu_i (.i_mclk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_addr(i_reg_addr),
        .o_wdata(i_reg_wdata));

    // 40 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    // pulse counters, hang guard
    always @(posedge i_mclk) begin
        wakes += int'(o_wake_event);
        ints += int'(!o_interrupt_out_n);
        if (++cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // writable bits per register, zero where unmapped
    function automatic logic [7:0] msk(input int a);
        case (a)
            3: return 8'hf7;
            4: return 8'h07;
            6: return 8'h44;
            7: return 8'ha1;
            default: return 8'h00;
        endcase
    endfunction : msk
    task automatic wr(input int a, input logic [7:0] d);
        mcu_i.write(a[6:0], d);
        m[a] = d & msk(a);
    endtask : wr
    task automatic ck(input int a);
        logic [7:0] q;
        mcu_i.read(a[6:0], q);
        `CHK(q, m[a])
    endtask : ck
    // mode change with the automatic transceiver and watchdog updates
    task automatic md(input swcw_mode_t n);
        if (n == SWCW_MODE_SLEEP && (m[4][1:0] == 2'h2 ||
                (m[4][1:0] == 2'h3 && !i_system_error_flag)))
            m[4][1:0] = 2'h1;
        if (n == SWCW_MODE_NORMAL && i_sbc_mode == SWCW_MODE_STOP)
            m[6][2] = 1'b0;
        @(negedge i_mclk);
        i_sbc_mode = n;
        repeat (3) @(negedge i_mclk);
    endtask : md

    // main sequence
    initial begin
        r = $urandom(71105);
        repeat (8) @(negedge i_mclk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_mclk);
        for (int a = 3; a < 9; a++) ck(a);
        for (int c = 0; c < 8; c++) begin
            r = $urandom;
            mcu_i.slow = c % 3;
            wr(3, mcu_i.wd_byte({r[3:0], c[2:0]}));
            wr(4, r[15:8]);
            wr(6, r[23:16]);
            wr(7, r[31:24]);
            for (int a = 3; a < 9; a++) ck(a);
            `CHK(o_wdog_period_ms, MS[c])
            `CHK(o_wdog_type_window, m[3][5])
            `CHK(o_wdog_cfg_parity_err, ^m[3])
            `CHK(o_wdog_stop_off, m[3][6] & m[6][2])
            `CHK(o_cyclic_timer_wake_enable, m[6][6])
            `CHK(o_voltage_sense_select, m[7][5])
            `CHK(o_can_mode, m[4][2:0])
        end
        mcu_i.slow = 0;
        for (int c = 0; c < 32; c++) begin
            i_system_error_flag = c[4];
            wr(6, 8'h44);
            wr(4, {5'h00, c[2:0]});
            md(c[3] ? SWCW_MODE_STOP : SWCW_MODE_SLEEP);
            ck(4);
            `CHK(o_can_mode, m[4][2:0])
            md(SWCW_MODE_NORMAL);
            ck(6);
        end
        for (int c = 0; c < 8; c++) begin
            wr(4, {5'h00, c[2:0]});
            i_fail_safe_entry = 1'b1;
            @(negedge i_mclk);
            i_fail_safe_entry = 1'b0;
            m[4] = {5'h00, c[2], 2'h1};
            ck(4);
        end
        for (int b = 0; b < 2; b++) begin
            wr(3, mcu_i.wd_byte({2'h0, b[0], 4'h4}));
            i_bus_wake_in_stop = 1'b1;
            @(negedge i_mclk);
            i_bus_wake_in_stop = 1'b0;
            `CHK(o_wdog_start_long_window, b[0])
        end
        for (int e = 0; e < 8; e++) begin
            wr(7, {e[2], 1'b0, e[1], 4'h0, e[0]});
            wr(6, {1'b0, e[0], 6'h00});
            repeat (4) @(negedge i_mclk);
            wakes = 0;
            ints = 0;
            ew = int'(e[0] & ~e[1]) + int'(e[0]);
            i_hv_wake_input = ~i_hv_wake_input;
            repeat (8) @(negedge i_mclk);
            i_status_event = 1'b1;
            @(negedge i_mclk);
            i_status_event = 1'b0;
            i_timer_wake = 1'b1;
            @(negedge i_mclk);
            i_timer_wake = 1'b0;
            repeat (4) @(negedge i_mclk);
            `CHK(wakes, ew)
            `CHK(ints, ew + int'(e[2]))
        end
        for (int d = 0; d < 2; d++) begin
            i_dev_mode_pin = d[0];
            repeat (3) @(negedge i_mclk);
            i_soft_reset = 1'b1;
            @(negedge i_mclk);
            i_soft_reset = 1'b0;
            m[3] = 8'h14;
            m[4] = {6'h00, d[0], d[0]};
            m[6] = 8'h00;
            m[7] = 8'h01;
            for (int a = 3; a < 8; a++) ck(a);
        end
        // power-on again with the strap still high
        i_resetn = 1'b0;
        @(negedge i_mclk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_mclk);
        for (int a = 3; a < 8; a++) ck(a);
        give_verdict();
    end
endmodule : testbench
